/* File: rtl/dgp_port.sv */
`timescale 1ns/1ps
module dgp_port (
   input  wire logic            pclk,
   input  wire logic            presetn,
   input  wire logic            psel,
   input  wire logic            penable,
   input  wire logic            pwrite,
   input  wire logic [11:0]     paddr,
   input  wire logic [31:0]     pwdata,
   input  wire logic [3:0]      pstrb,
   output      logic [31:0]     prdata,
   output      logic            pready,
   output      logic            pslverr,
   input  wire logic [7:0]      pc_in,
   input  wire logic [7:0]      pd_in,
   output      dgp_pkg::dgp_drive_t pc_drv,
   output      dgp_pkg::dgp_drive_t pd_drv,
   input  wire dgp_pkg::dgp_alt_t   alt,
   input  wire logic            programming_mode,
   output      logic            serial_sda_in,
   output      logic            serial_scl_in,
   output      logic            timer_clock_in,
   output      logic            timer_clock_select,
   output      logic [3:0]      analog_select,
   output      logic            change_interrupt
);
   ////////////////////////////////////////////////////////////////////////////
   // registers
   logic [7:0]  port_c_data;
   logic [7:0]  port_d_data;
   logic [7:0]  port_c_direction;
   logic [7:0]  port_d_direction;
   logic [31:0] control;
   logic        change_interrupt_flag;
   logic [3:0]  change_ref;
   logic [7:0]  pc_s1, pc_s2, pd_s1, pd_s2;

   ////////////////////////////////////////////////////////////////////////////
   // pin synchronisers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pc_s1 <= 8'h00;
         pc_s2 <= 8'h00;
         pd_s1 <= 8'h00;
         pd_s2 <= 8'h00;
      end else begin
         pc_s1 <= pc_in;
         pc_s2 <= pc_s1;
         pd_s1 <= pd_in;
         pd_s2 <= pd_s1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // mode decode
   wire serial_en  = control[dgp_pkg::CTL_SERIAL_EN];
   wire serial_sel = control[dgp_pkg::CTL_SERIAL_SEL];
   wire cmpa_oe    = control[dgp_pkg::CTL_CMPA_OE];
   wire cmpb_oe    = control[dgp_pkg::CTL_CMPB_OE];
   wire pullup_n   = control[dgp_pkg::CTL_PULLUP_N];
   wire change_ie  = control[dgp_pkg::CTL_CHANGE_IE];
   wire [3:0] analog = control[dgp_pkg::CTL_ANALOG_LSB +: dgp_pkg::CTL_ANALOG_W];
   wire serial_c   = (serial_en && !serial_sel) || programming_mode;
   wire serial_d   = serial_en && serial_sel;

   // default: latch drives where direction bit is zero
   wire [7:0] c_gpio_oe = ~port_c_direction;
   wire [7:0] d_gpio_oe = ~port_d_direction;

   logic [7:0] next_pc_o, next_pc_oe, next_pc_pu;
   logic [7:0] next_pd_o, next_pd_oe, next_pd_pu;
   always_comb begin
      next_pc_o  = port_c_data;
      next_pc_oe = c_gpio_oe;
      next_pc_pu = {2'b11, {6{~pullup_n}} & port_c_direction[5:0]};
      if (serial_c) begin
         next_pc_o[7:6]  = {alt.serial_sda_o, alt.serial_scl_o};
         next_pc_oe[7:6] = {alt.serial_sda_oe, alt.serial_scl_oe};
         next_pc_pu[7:6] = 2'b00;
      end
      if (cmpa_oe) begin
         next_pc_o[1:0]  = {alt.comparator_a, alt.reference_a};
         next_pc_oe[1:0] = 2'b11;
         next_pc_pu[1:0] = 2'b00;
      end
      next_pd_o  = port_d_data;
      next_pd_oe = d_gpio_oe & ~{analog, 4'h0};
      next_pd_pu = 8'h03;
      if (cmpb_oe) begin
         next_pd_o[3:2]  = {alt.reference_b, alt.comparator_b};
         next_pd_oe[3:2] = 2'b11;
      end
      if (serial_d) begin
         next_pd_o[1:0]  = {alt.serial_sda_o, alt.serial_scl_o};
         next_pd_oe[1:0] = {alt.serial_sda_oe, alt.serial_scl_oe};
         next_pd_pu[1:0] = 2'b00;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // read values and change detect
   wire [7:0] pd_read = pd_s2 & ~{analog, 4'h0};
   wire [3:0] change_inputs = port_c_direction[7:4]
                            & ~{serial_c, serial_c, 2'b00};
   wire [3:0] mismatch = (pc_s2[7:4] ^ change_ref) & change_inputs;
   wire       change_hit = |mismatch;

   ////////////////////////////////////////////////////////////////////////////
   // apb decode
   wire acc      = psel && penable;
   wire wr       = acc && pwrite;
   wire rd       = acc && !pwrite;
   wire hit_pc   = paddr == dgp_pkg::OFF_PORT_C_DATA;
   wire hit_pd   = paddr == dgp_pkg::OFF_PORT_D_DATA;
   wire hit_pcd  = paddr == dgp_pkg::OFF_PORT_C_DIRECTION;
   wire hit_pdd  = paddr == dgp_pkg::OFF_PORT_D_DIRECTION;
   wire hit_ctl  = paddr == dgp_pkg::OFF_CONTROL;
   wire hit_sts  = paddr == dgp_pkg::OFF_STATUS;
   wire mapped   = hit_pc | hit_pd | hit_pcd | hit_pdd | hit_ctl | hit_sts;
   wire b0       = pstrb[0];
   wire sts_clr  = wr && hit_sts && b0 && pwdata[dgp_pkg::STS_CHANGE_FLAG];

   logic [31:0] next_prdata;
   always_comb begin
      next_prdata = 32'h0000_0000;
      if (hit_pc) next_prdata[7:0] = pc_s2;
      if (hit_pd) next_prdata[7:0] = pd_read;
      if (hit_pcd) next_prdata[7:0] = port_c_direction;
      if (hit_pdd) next_prdata[7:0] = port_d_direction;
      if (hit_ctl) next_prdata = control;
      if (hit_sts) next_prdata[dgp_pkg::STS_CHANGE_FLAG] = change_interrupt_flag;
   end

   ////////////////////////////////////////////////////////////////////////////
   // register writes
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         port_c_data      <= dgp_pkg::RST_DATA;
         port_d_data      <= dgp_pkg::RST_DATA;
         port_c_direction <= dgp_pkg::RST_DIRECTION;
         port_d_direction <= dgp_pkg::RST_DIRECTION;
         control          <= dgp_pkg::RST_CONTROL;
      end else if (wr && b0) begin
         if (hit_pc) port_c_data <= pwdata[7:0];
         if (hit_pd) port_d_data <= pwdata[7:0];
         if (hit_pcd) port_c_direction <= pwdata[7:0];
         if (hit_pdd) port_d_direction <= pwdata[7:0];
         if (hit_ctl) control <= {20'h00000, pwdata[11:8], 1'b0, pwdata[6:0]};
      end else if (wr && hit_ctl && pstrb[1]) begin
         control[11:8] <= pwdata[11:8];
      end
   end

   // port c read refreshes the compare value; set wins over clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         change_ref            <= 4'h0;
         change_interrupt_flag <= 1'b0;
      end else begin
         if (rd && hit_pc) change_ref <= pc_s2[7:4];
         if (change_hit) change_interrupt_flag <= 1'b1;
         else if (sts_clr) change_interrupt_flag <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // registered outputs
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pc_drv             <= '0;
         pd_drv             <= '0;
         prdata             <= 32'h0000_0000;
         pready             <= 1'b0;
         pslverr            <= 1'b0;
         serial_sda_in      <= 1'b1;
         serial_scl_in      <= 1'b1;
         timer_clock_in     <= 1'b0;
         timer_clock_select <= 1'b0;
         analog_select      <= 4'h0;
         change_interrupt   <= 1'b0;
      end else begin
         pc_drv             <= '{o: next_pc_o, oe: next_pc_oe, pu: next_pc_pu};
         pd_drv             <= '{o: next_pd_o, oe: next_pd_oe, pu: next_pd_pu};
         pready             <= acc && !pready;
         pslverr            <= acc && !pready && !mapped;
         prdata             <= (rd && !pready) ? next_prdata : 32'h0000_0000;
         serial_sda_in      <= serial_d ? pd_s2[1] : pc_s2[7];
         serial_scl_in      <= serial_d ? pd_s2[0] : pc_s2[6];
         timer_clock_in     <= pc_s2[3];
         timer_clock_select <= control[dgp_pkg::CTL_TIMER_EXT];
         analog_select      <= analog;
         change_interrupt   <= change_interrupt_flag && change_ie;
      end
   end
endmodule

/* File: pkg/dgp_pkg.sv */
// Contract
// - pc7 is serial data, programming data, or gpio
// - pc6 is serial clock, programming clock, or gpio
// - pc7/pc6 pull-up off in serial mode
// - change on pc7..pc4 raises interrupt request
// - pc5..pc0 weak pull-ups when enabled
// - pc3 feeds timer clock when option selects
// - pc1 is gpio or comparator a output
// - pc0 is gpio or reference a output
// - direction bit one input, zero output
// - port c direction resets to all ones
// - serial mode overrides pc7/pc6 direction
// - comparator a enable overrides pc1/pc0 direction
// - port d is eight gpio pins
// - pd7..pd4 selectable as analog inputs
// - pd7..pd4 digital input reads pin
// - pd7..pd4 analog input reads zero
// - pd3 is gpio or reference b output
// - pd2 is gpio or comparator b output
// - select bit moves serial lines to pd1/pd0
// - pd1/pd0 pull-up off in serial mode
// - comparator a enable claims pc0/pc1 pins
// - comparator b enable claims pd3/pd2 pins
// - change compares inputs against last read
// - active-low enable turns on pc5..pc0 pull-ups
package dgp_pkg;
   // register index; byte address is four times the index
   localparam logic [9:0]  IDX_PORT_C_DATA      = 10'h007;
   localparam logic [9:0]  IDX_PORT_D_DATA      = 10'h008;
   localparam logic [9:0]  IDX_PORT_C_DIRECTION = 10'h087;
   localparam logic [9:0]  IDX_PORT_D_DIRECTION = 10'h088;
   localparam logic [11:0] OFF_PORT_C_DATA      = {IDX_PORT_C_DATA, 2'b00};
   localparam logic [11:0] OFF_PORT_D_DATA      = {IDX_PORT_D_DATA, 2'b00};
   localparam logic [11:0] OFF_PORT_C_DIRECTION = {IDX_PORT_C_DIRECTION, 2'b00};
   localparam logic [11:0] OFF_PORT_D_DIRECTION = {IDX_PORT_D_DIRECTION, 2'b00};
   localparam logic [11:0] OFF_CONTROL          = 12'h300;
   localparam logic [11:0] OFF_STATUS           = 12'h304;
   localparam logic [7:0]  RST_DIRECTION        = 8'hFF;
   localparam logic [7:0]  RST_DATA             = 8'h00;
   localparam logic [7:0]  RST_ANALOG           = 8'h00;
   // control register fields
   localparam int CTL_SERIAL_EN   = 0;
   localparam int CTL_SERIAL_SEL  = 1;
   localparam int CTL_CMPA_OE     = 2;
   localparam int CTL_CMPB_OE     = 3;
   localparam int CTL_PULLUP_N    = 4;
   localparam int CTL_TIMER_EXT   = 5;
   localparam int CTL_CHANGE_IE   = 6;
   localparam int CTL_ANALOG_LSB  = 8;
   localparam int CTL_ANALOG_W    = 4;
   localparam logic [31:0] RST_CONTROL = 32'h0000_0010;
   // status register fields
   localparam int STS_CHANGE_FLAG = 0;

   typedef struct packed {
      logic [7:0] o;
      logic [7:0] oe;
      logic [7:0] pu;
   } dgp_drive_t;

   // alternate function signals from other modules
   typedef struct packed {
      logic serial_sda_o;
      logic serial_sda_oe;
      logic serial_scl_o;
      logic serial_scl_oe;
      logic comparator_a;
      logic reference_a;
      logic comparator_b;
      logic reference_b;
   } dgp_alt_t;
endpackage

/* File: verif/dgp_port_monitor.sv */
`timescale 1ns/1ps
module dgp_port_monitor (
   input wire logic                pclk,
   input wire logic                presetn,
   input wire logic                psel,
   input wire logic                penable,
   input wire logic [11:0]         paddr,
   input wire logic [31:0]         prdata,
   input wire logic                pready,
   input wire logic                pslverr,
   input wire dgp_pkg::dgp_drive_t pc_drv,
   input wire dgp_pkg::dgp_drive_t pd_drv
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   chk_ready_next: assert property (psel && penable && !pready |=> pready) else $error("no ready");
   chk_ready_pulse: assert property (pready |=> !pready) else $error("ready too long");
   chk_err_ready: assert property (pslverr |-> pready) else $error("error without ready");
   chk_rdata_idle: assert property (!pready |-> prdata == 32'h0) else $error("stray read data");
   chk_unmapped_err: assert property (pready && paddr == 12'h004 |-> pslverr)
      else $error("no error on hole");
   chk_mapped_ok: assert property (pready && paddr == dgp_pkg::OFF_PORT_C_DIRECTION |-> !pslverr)
      else $error("error on register");
   chk_pullup_out: assert property ((pc_drv.pu[5:0] & pc_drv.oe[5:0]) == 6'h0)
      else $error("pull-up on output");
   chk_reset_inputs: assert property ($rose(presetn) |-> (pc_drv.oe | pd_drv.oe) == 8'h00)
      else $error("pin driven after reset");
endmodule
bind dgp_port dgp_port_monitor i_mon (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .pc_drv(pc_drv), .pd_drv(pd_drv));

/* File: verif/dgp_pins.sv */
`timescale 1ns/1ps
module dgp_pins (
   input wire dgp_pkg::dgp_drive_t pc_drv,
   input wire dgp_pkg::dgp_drive_t pd_drv,
   input wire logic [7:0]          ext_c,
   input wire logic [7:0]          ext_d,
   output     logic [7:0]          pc_in,
   output     logic [7:0]          pd_in
);
   // driven pin wins, then pull-up, then the far-side level
   assign pc_in = (pc_drv.oe & pc_drv.o) | (~pc_drv.oe & (pc_drv.pu | ext_c));
   assign pd_in = (pd_drv.oe & pd_drv.o) | (~pd_drv.oe & (pd_drv.pu | ext_d));
endmodule

/* File: verif/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
   logic                pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic                pready, tsel, tin, irq, sdi, sci, pmode = 0;
   logic [3:0]          asel;
   logic [7:0]          pc_in, pd_in, v, d, a, ext_c = '0, ext_d = '0;
   logic [11:0]         paddr = '0;
   logic [31:0]         pwdata = '0, prdata, seed = 32'h1E29, expq[$];
   int                  error_cnt = 0, compares = 0;
   dgp_pkg::dgp_drive_t pc_drv, pd_drv;
   dgp_pkg::dgp_alt_t   alt = '0;
   always #2 pclk = ~pclk;
   dgp_port i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata),
      .pready(pready), .pslverr(), .pc_in(pc_in), .pd_in(pd_in), .pc_drv(pc_drv),
      .pd_drv(pd_drv), .alt(alt), .programming_mode(pmode), .serial_sda_in(sdi),
      .serial_scl_in(sci), .timer_clock_in(tin), .timer_clock_select(tsel),
      .analog_select(asel), .change_interrupt(irq));
   dgp_pins i_pins (.pc_drv(pc_drv), .pd_drv(pd_drv), .ext_c(ext_c), .ext_d(ext_d),
      .pc_in(pc_in), .pd_in(pd_in));
   ////////////////////////////////////////
   function automatic logic [7:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed[7:0];
   endfunction
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      compares++;
      if (g !== e) begin
         error_cnt++;
         $display("wrong value %s exp %h got %h", n, e, g);
      end
   endtask
   task automatic summarize();
      if (error_cnt == 0 && compares > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   task automatic xfer(input logic w, input logic [11:0] ad, input logic [31:0] dt);
      if (!w) expq.push_back(dt);
      @(posedge pclk);
      psel <= 1;
      pwrite <= w;
      paddr <= ad;
      pwdata <= dt;
      @(posedge pclk);
      penable <= 1;
      do @(posedge pclk); while (pready !== 1'b1);
      psel <= 0;
      penable <= 0;
      if (w) repeat (8) @(posedge pclk);
   endtask
   task automatic wr(input logic [11:0] ad, input logic [11:0] dt);
      xfer(1'b1, ad, {20'h0, dt});
   endtask
   task automatic rd(input logic [11:0] ad, input logic [7:0] dt);
      xfer(1'b0, ad, {24'h0, dt});
   endtask
   // read results checked in order of issue
   always @(posedge pclk) begin
      if (pready === 1'b1 && psel && !pwrite) chk("prdata", expq.pop_front(), prdata);
   end
   initial begin
      repeat (4000) @(posedge pclk);
      error_cnt++;
      summarize();
   end
   initial begin
      repeat (5) @(posedge pclk);
      presetn <= 1;
      ext_c <= rnd();
      ext_d <= rnd();
      repeat (8) @(posedge pclk);
      rd(dgp_pkg::OFF_PORT_C_DIRECTION, 8'hFF);
      rd(dgp_pkg::OFF_PORT_D_DATA, ext_d | 8'h03);
      rd(dgp_pkg::OFF_PORT_C_DATA, ext_c | 8'hC0);
      rd(12'h004, 8'h00);
      v = rnd();
      d = rnd();
      wr(dgp_pkg::OFF_PORT_C_DATA, {4'h0, v});
      wr(dgp_pkg::OFF_PORT_C_DIRECTION, {4'h0, d});
      rd(dgp_pkg::OFF_PORT_C_DATA, (v & ~d) | (d & (ext_c | 8'hC0)));
      wr(dgp_pkg::OFF_CONTROL, 12'h000);
      chk("pc_pu", 32'({2'b11, d[5:0]}), 32'(pc_drv.pu));
      rd(dgp_pkg::OFF_PORT_C_DATA, v | d);
      a = rnd();
      alt <= {4'h0, a[0], a[1], a[2], a[3]};
      wr(dgp_pkg::OFF_CONTROL, 12'hF1C);
      rd(dgp_pkg::OFF_PORT_C_DATA,
         (((v & ~d) | (d & (ext_c | 8'hC0))) & 8'hFC) | {6'h0, a[0], a[1]});
      rd(dgp_pkg::OFF_PORT_D_DATA, {4'h0, a[3], a[2], 2'b11});
      chk("asel", 32'h0000000F, 32'(asel));
      alt <= 8'h40;
      wr(dgp_pkg::OFF_PORT_C_DATA, 12'h0FF);
      wr(dgp_pkg::OFF_PORT_C_DIRECTION, 12'h000);
      wr(dgp_pkg::OFF_CONTROL, 12'h011);
      rd(dgp_pkg::OFF_PORT_C_DATA, {1'b0, ext_c[6], 6'h3F});
      chk("pc_pu", 32'h0, 32'(pc_drv.pu));
      wr(dgp_pkg::OFF_CONTROL, 12'h013);
      rd(dgp_pkg::OFF_PORT_D_DATA, {ext_d[7:2], 1'b0, ext_d[0]});
      chk("pd_pu", 32'h0, 32'(pd_drv.pu));
      chk("sda_in", 32'h0, 32'(sdi));
      chk("scl_in", 32'(ext_d[0]), 32'(sci));
      pmode <= 1'b1;
      wr(dgp_pkg::OFF_CONTROL, 12'h010);
      rd(dgp_pkg::OFF_PORT_C_DATA, {1'b0, ext_c[6], 6'h3F});
      pmode <= 1'b0;
      alt <= '0;
      wr(dgp_pkg::OFF_PORT_C_DIRECTION, 12'h0FF);
      wr(dgp_pkg::OFF_CONTROL, 12'h070);
      chk("tsel", 32'h1, 32'(tsel));
      chk("tin", 32'(ext_c[3]), 32'(tin));
      rd(dgp_pkg::OFF_PORT_C_DATA, ext_c | 8'hC0);
      wr(dgp_pkg::OFF_STATUS, 12'h001);
      chk("irq", 32'h0, 32'(irq));
      ext_c <= ext_c ^ 8'h10;
      repeat (8) @(posedge pclk);
      chk("irq", 32'h1, 32'(irq));
      rd(dgp_pkg::OFF_PORT_C_DATA, ext_c | 8'hC0);
      wr(dgp_pkg::OFF_STATUS, 12'h001);
      chk("irq", 32'h0, 32'(irq));
      summarize();
   end
endmodule
